// >>> core/msi_capability_logic.sv
// Message-signalled interrupt capability registers and message generator
`timescale 1ns/1ns
module msi_capability_logic #(
	parameter logic [7:0] NEXT_PTR = msi_cap_pkg::NEXT_PTR_DEFAULT,
	parameter logic ADDR64_CAPABLE = msi_cap_pkg::ADDR64_CAPABLE_DEFAULT
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Configuration access, offset relative to capability base
	input  wire logic        cfgWrEn,
	input  wire logic        cfgRdEn,
	input  wire logic [7:0]  cfgOffset,
	input  wire logic [3:0]  cfgByteEn,
	input  wire logic [31:0] cfgWrData,
	output logic      [31:0] cfgRdData,
	output logic             cfgRdValid,
	// Interrupt events from the controller core
	input  wire logic        intEvent,
	input  wire logic [4:0]  intVector,
	input  wire logic        intxClear,
	// Legacy interrupt pin level
	output logic             intxAssert,
	// Message memory write toward the transaction layer
	output logic             msgWrValid,
	input  wire logic        msgWrReady,
	output logic [63:0]      msgWrAddr,
	output logic             msgWrAddr64,
	output logic [31:0]      msgWrData,
	// Current mode
	output logic             msgEnabled
);

	logic        enable_q;
	logic [2:0]  alloc_q;
	logic [29:0] addrLow_q;
	logic [31:0] addrHigh_q;
	logic [15:0] payload_q;
	logic        pending_q;
	logic [4:0]  vector_q;
	msi_cap_pkg::deliver_e state_q;
	logic [31:0] rdData_q;
	logic        rdValid_q;
	logic        intx_q;
	logic        wrValid_q;
	logic [63:0] wrAddr_q;
	logic        wrAddr64_q;
	logic [31:0] wrData_q;

	logic [15:0] controlWord;
	logic [7:0]  dataOffset;
	logic        useHigh;
	logic        sent;
	logic [4:0]  vecMask;

	// Register selects and byte-merged write images
	logic        selControl;
	logic        selAddrLow;
	logic        selAddrHigh;
	logic        selData;
	logic [31:0] ctlMerged;
	logic [31:0] addrLowMerged;
	logic [31:0] payloadMerged;

	// Message image and event capture
	logic [4:0]  vectorBits;
	logic [31:0] msgDataNext;
	logic [63:0] msgAddrNext;
	logic        legacyCleared;
	logic        loadVector;

	// Byte-enabled merge of a write into a stored dword
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				res[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Vector bits that the allocated count lets the device vary
	function automatic logic [4:0] alloc_mask(input logic [2:0] code);
		logic [4:0] m;
		m = 5'h00;
		for (int i = 0; i < 5; i++)
		begin
			if (32'(code) > i)
			begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	assign controlWord = {msi_cap_pkg::CTL_RSVD, ADDR64_CAPABLE, alloc_q,
		msi_cap_pkg::REQ_ONE, enable_q};
	assign dataOffset = ADDR64_CAPABLE ? msi_cap_pkg::OFS_DATA_64 : msi_cap_pkg::OFS_DATA_32;
	assign useHigh = ADDR64_CAPABLE && (addrHigh_q != msi_cap_pkg::ZERO32);
	assign sent = wrValid_q && msgWrReady;
	assign vecMask = alloc_mask(alloc_q);

	// Offset decode shared by writes and reads
	assign selControl = cfgOffset == msi_cap_pkg::OFS_CONTROL;
	assign selAddrLow = cfgOffset == msi_cap_pkg::OFS_ADDR_LOW;
	assign selAddrHigh = ADDR64_CAPABLE && cfgOffset == msi_cap_pkg::OFS_ADDR_HIGH;
	assign selData = cfgOffset == dataOffset;

	// Read-only bits re-enter the merge from their fixed values
	assign ctlMerged = merge({controlWord, msi_cap_pkg::ZERO16}, cfgWrData, cfgByteEn);
	assign addrLowMerged = merge({addrLow_q, msi_cap_pkg::ADDR_LOW_RO}, cfgWrData,
		cfgByteEn);
	assign payloadMerged = merge({msi_cap_pkg::ZERO16, payload_q}, cfgWrData, cfgByteEn);

	// Allocated vector bits replace the low payload bits
	assign vectorBits = (payload_q[4:0] & ~vecMask) | (vector_q & vecMask);
	assign msgDataNext = {msi_cap_pkg::ZERO16, payload_q[15:5], vectorBits};
	assign msgAddrNext = {(useHigh ? addrHigh_q : msi_cap_pkg::ZERO32), addrLow_q,
		msi_cap_pkg::ADDR_LOW_RO};

	// A legacy clear only retires the event while messages stay off
	assign legacyCleared = state_q == msi_cap_pkg::ST_LEGACY && !enable_q && intxClear;
	assign loadVector = !pending_q || sent || legacyCleared;

	// Control word writes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			enable_q <= 1'b0;
			alloc_q <= msi_cap_pkg::ALLOC_RESET;
		end
		else if (cfgWrEn && selControl)
		begin
			enable_q <= ctlMerged[msi_cap_pkg::CTL_WORD_LO + msi_cap_pkg::CTL_ENABLE];
			alloc_q <= ctlMerged[msi_cap_pkg::CTL_WORD_LO + msi_cap_pkg::CTL_ALLOC_HI:
				msi_cap_pkg::CTL_WORD_LO + msi_cap_pkg::CTL_ALLOC_LO];
		end
	end

	// Address and data registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			addrLow_q <= 30'h0000_0000;
			addrHigh_q <= msi_cap_pkg::ZERO32;
			payload_q <= msi_cap_pkg::ZERO16;
		end
		else if (cfgWrEn)
		begin
			if (selAddrLow)
			begin
				addrLow_q <= addrLowMerged[31:msi_cap_pkg::ADDR_ALIGN_BITS];
			end
			else if (selAddrHigh)
			begin
				addrHigh_q <= merge(addrHigh_q, cfgWrData, cfgByteEn);
			end
			else if (selData)
			begin
				payload_q <= payloadMerged[15:0];
			end
		end
	end

	// Configuration reads, one cycle latency
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdData_q <= msi_cap_pkg::ZERO32;
			rdValid_q <= 1'b0;
		end
		else
		begin
			rdValid_q <= cfgRdEn;
			if (cfgRdEn)
			begin
				if (selControl)
				begin
					rdData_q <= {controlWord, NEXT_PTR, msi_cap_pkg::CAP_ID};
				end
				else if (selAddrLow)
				begin
					rdData_q <= {addrLow_q, msi_cap_pkg::ADDR_LOW_RO};
				end
				else if (selAddrHigh)
				begin
					rdData_q <= addrHigh_q;
				end
				else if (selData)
				begin
					rdData_q <= {msi_cap_pkg::ZERO16, payload_q};
				end
				else
				begin
					rdData_q <= msi_cap_pkg::ZERO32;
				end
			end
		end
	end

	// Pending event; a new event wins over the clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pending_q <= 1'b0;
		end
		else if (intEvent)
		begin
			pending_q <= 1'b1;
		end
		else if (sent || legacyCleared)
		begin
			pending_q <= 1'b0;
		end
	end

	// Vector of the event being delivered; later events while waiting coalesce
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			vector_q <= 5'h00;
		end
		else if (intEvent && loadVector)
		begin
			vector_q <= intVector;
		end
	end

	// Delivery: message write or legacy level, never both
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= msi_cap_pkg::ST_IDLE;
			intx_q <= 1'b0;
			wrValid_q <= 1'b0;
			wrAddr_q <= 64'h0;
			wrAddr64_q <= 1'b0;
			wrData_q <= msi_cap_pkg::ZERO32;
		end
		else
		begin
			case (state_q)
				msi_cap_pkg::ST_IDLE:
				begin
					if (pending_q && !sent)
					begin
						if (enable_q)
						begin
							state_q <= msi_cap_pkg::ST_SEND;
							wrValid_q <= 1'b1;
							wrAddr_q <= msgAddrNext;
							wrAddr64_q <= useHigh;
							wrData_q <= msgDataNext;
						end
						else
						begin
							state_q <= msi_cap_pkg::ST_LEGACY;
							intx_q <= 1'b1;
						end
					end
				end
				msi_cap_pkg::ST_LEGACY:
				begin
					// Enabling messages drops the level; the event stays pending
					if (enable_q)
					begin
						intx_q <= 1'b0;
						state_q <= msi_cap_pkg::ST_IDLE;
					end
					else if (intxClear)
					begin
						intx_q <= 1'b0;
						state_q <= msi_cap_pkg::ST_IDLE;
					end
				end
				msi_cap_pkg::ST_SEND:
				begin
					if (msgWrReady)
					begin
						wrValid_q <= 1'b0;
						state_q <= msi_cap_pkg::ST_IDLE;
					end
				end
				default:
				begin
					state_q <= msi_cap_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign cfgRdData = rdData_q;
	assign cfgRdValid = rdValid_q;
	assign intxAssert = intx_q;
	assign msgWrValid = wrValid_q;
	assign msgWrAddr = wrAddr_q;
	assign msgWrAddr64 = wrAddr64_q;
	assign msgWrData = wrData_q;
	assign msgEnabled = enable_q;

endmodule

// >>> core/msi_cap_pkg.sv
// Constants for the message-signalled interrupt capability
//
// Operation
// - Address dword at base plus 4, data at plus 8 in 32-bit layout.
// - Control bits 15 to 8 read zero and ignore writes.
// - Control bit 7 is a read-only 64-bit address capability flag.
// - Control bits 6 to 4 hold allocated vectors, 1 up to 32; writes of 6 or 7 are kept, read back and act as 32.
// - Allocated-vector field clears to 000 on reset.
// - Control bits 3 to 1 read 000, one vector requested.
// - Enable bit 0 selects messages and silences the legacy pin.
// - Message enable is 0 after reset.
// - Address bits 31 to 2 writable, bits 1 to 0 read 00.
// - Upper address is a 32-bit writable register.
// - Upper address used only when 64-bit capability is set.
// - Upper address of zero gives 32-bit addressed writes.
// - Message data drives the low word of the write data.
package msi_cap_pkg;
	// Capability dword offsets, bytes from the capability base
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_ADDR_LOW = 8'h04;
	localparam logic [7:0] OFS_DATA_32 = 8'h08;
	localparam logic [7:0] OFS_ADDR_HIGH = 8'h08;
	localparam logic [7:0] OFS_DATA_64 = 8'h0c;

	// Fixed header fields
	localparam logic [7:0] CAP_ID = 8'h05;
	localparam logic [7:0] NEXT_PTR_DEFAULT = 8'h00;
	localparam logic ADDR64_CAPABLE_DEFAULT = 1'b1;

	// Control word bit positions
	localparam int CTL_ENABLE = 0;
	localparam int CTL_REQ_LO = 1;
	localparam int CTL_ALLOC_LO = 4;
	localparam int CTL_ALLOC_HI = 6;
	localparam int CTL_ADDR64 = 7;
	localparam int CTL_WORD_LO = 16;
	localparam int ADDR_ALIGN_BITS = 2;

	// Reset values and read-only codes
	localparam logic [2:0] ALLOC_RESET = 3'h0;
	localparam logic [2:0] REQ_ONE = 3'h0;
	localparam logic [2:0] ALLOC_MAX = 3'h5;
	localparam logic [7:0] CTL_RSVD = 8'h00;
	localparam logic [1:0] ADDR_LOW_RO = 2'h0;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [15:0] ZERO16 = 16'h0000;

	// Interrupt delivery states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEGACY = 2'b10,
		ST_SEND = 2'b01
	} deliver_e;
endpackage

// >>> test/msi_monitor.sv
// Port-level assertions for the capability block
`timescale 1ns/1ns
module msi_monitor #(
	parameter logic ADDR64_CAPABLE = 1'b1
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Configuration reads
	input wire logic        cfgRdEn,
	input wire logic [7:0]  cfgOffset,
	input wire logic [31:0] cfgRdData,
	input wire logic        cfgRdValid,
	// Interrupt outputs
	input wire logic        intxAssert,
	input wire logic        msgWrValid,
	input wire logic        msgWrReady,
	input wire logic [63:0] msgWrAddr,
	input wire logic        msgWrAddr64,
	input wire logic [31:0] msgWrData,
	input wire logic        msgEnabled
);
	logic [7:0] rdOfs_q;
	logic       ctlRd;
	always_ff @(posedge clk)
	begin
		if (cfgRdEn)
			rdOfs_q <= cfgOffset;
	end
	assign ctlRd = cfgRdValid && rdOfs_q == 8'h00;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_rd_answer: assert property (cfgRdEn |=> cfgRdValid)
		else $error("read unanswered");
	a_rsvd_zero: assert property (ctlRd |-> cfgRdData[31:24] == 8'h00)
		else $error("reserved bits set");
	a_cap64_flag: assert property (ctlRd |-> cfgRdData[23] == ADDR64_CAPABLE)
		else $error("capability flag wrong");
	a_req_one: assert property (ctlRd |-> cfgRdData[19:17] == 3'h0)
		else $error("request code wrong");
	a_addr_align: assert property (cfgRdValid && rdOfs_q == 8'h04 |-> cfgRdData[1:0] == 2'h0)
		else $error("address low bits set");
	a_mode_excl: assert property (msgEnabled [*3] |-> !intxAssert)
		else $error("legacy level with messages on");
	a_reset_off: assert property ($past(rst) |-> !msgEnabled && !msgWrValid)
		else $error("not idle after reset");
	a_wr_hold: assert property (msgWrValid && !msgWrReady |=> msgWrValid && $stable(msgWrAddr))
		else $error("write request dropped");
	a_one_write: assert property (msgWrValid && msgWrReady |=> !msgWrValid)
		else $error("extra write");
	a_addr32_only: assert property (msgWrValid && !msgWrAddr64 |-> msgWrAddr[63:32] == 32'h0)
		else $error("upper bits in short write");
	a_data_high: assert property (msgWrValid |-> msgWrData[31:16] == 16'h0000)
		else $error("message data upper word set");
	a_hi_gated: assert property (msgWrValid && msgWrAddr64 |-> ADDR64_CAPABLE && |msgWrAddr[63:32])
		else $error("long header misused");
endmodule
bind msi_capability_logic msi_monitor #(.ADDR64_CAPABLE(ADDR64_CAPABLE)) mon (.clk, .rst,
	.cfgRdEn, .cfgOffset, .cfgRdData, .cfgRdValid, .intxAssert, .msgWrValid, .msgWrReady,
	.msgWrAddr, .msgWrAddr64, .msgWrData, .msgEnabled);

// >>> test/tl_partner.sv
// Transaction layer model that accepts message writes
`timescale 1ns/1ns
module tl_partner (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Message write
	input  wire logic        msgWrValid,
	input  wire logic [63:0] msgWrAddr,
	input  wire logic [31:0] msgWrData,
	output logic             msgWrReady,
	// Pacing and record
	input  wire logic        slow,
	output int               nWrites,
	output logic [63:0]      lastAddr,
	output logic [31:0]      lastData
);
	logic [1:0] waitCnt_q;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			msgWrReady <= 1'b0;
			waitCnt_q <= 2'h0;
			nWrites <= 0;
		end
		else if (msgWrValid && msgWrReady)
		begin
			lastAddr <= msgWrAddr;
			lastData <= msgWrData;
			nWrites <= nWrites + 1;
			msgWrReady <= 1'b0;
			waitCnt_q <= 2'h0;
		end
		else if (msgWrValid)
		begin
			// Slow mode stalls three cycles
			msgWrReady <= !slow || waitCnt_q == 2'h3;
			waitCnt_q <= waitCnt_q + 2'h1;
		end
	end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the capability block
`timescale 1ns/1ns
module tb_top;
	logic        clk, rst, cfgWrEn, cfgRdEn, cfgRdValid, intEvent, intxClear, intxAssert;
	logic        msgWrValid, msgWrReady, msgWrAddr64, msgEnabled, slow;
	logic [3:0]  cfgByteEn;
	logic [4:0]  intVector;
	logic [7:0]  cfgOffset;
	logic [31:0] cfgWrData, cfgRdData, msgWrData, lastData;
	logic [63:0] msgWrAddr, lastAddr;
	int          fails, n_tests, nWrites, cyc, base;
	msi_capability_logic dut (.clk, .rst, .cfgWrEn, .cfgRdEn, .cfgOffset, .cfgByteEn,
		.cfgWrData, .cfgRdData, .cfgRdValid, .intEvent, .intVector, .intxClear,
		.intxAssert, .msgWrValid, .msgWrReady, .msgWrAddr, .msgWrAddr64, .msgWrData,
		.msgEnabled);
	tl_partner tl (.clk, .rst, .msgWrValid, .msgWrAddr, .msgWrData, .msgWrReady,
		.slow, .nWrites, .lastAddr, .lastData);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			wrap_up();
		end
	end
	task automatic check(input string nm, input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cfgWrite(input logic [7:0] o, input logic [31:0] d,
		input logic [3:0] be = 4'hf);
		@(posedge clk) #5 {cfgWrEn, cfgOffset, cfgWrData, cfgByteEn} = {1'b1, o, d, be};
		@(posedge clk) #5 cfgWrEn = 1'b0;
	endtask
	task automatic cfgRead(input logic [7:0] o, input logic [31:0] e);
		@(posedge clk) #5 {cfgRdEn, cfgOffset} = {1'b1, o};
		@(posedge clk) #5 cfgRdEn = 1'b0;
		check("rdvalid", cfgRdValid, 1'b1);
		check("rddata", cfgRdData, e);
	endtask
	task automatic fire(input logic [4:0] v);
		@(posedge clk) #5 {intEvent, intVector} = {1'b1, v};
		@(posedge clk) #5 intEvent = 1'b0;
	endtask
	task automatic waitWr(input int n);
		for (int k = 0; k < 20 && nWrites < n; k++)
			@(posedge clk);
		#5 check("count", nWrites, n);
	endtask
	task automatic msgCase(input logic [4:0] v, input logic [63:0] ea, input logic [31:0] ed);
		base = nWrites;
		fire(v);
		waitWr(base + 1);
		check("addr", lastAddr, ea);
		check("data", lastData, ed);
		check("intx", intxAssert, 1'b0);
		check("addr64", msgWrAddr64, ea[63:32] != 32'h0);
		check("enabled", msgEnabled, 1'b1);
	endtask
	initial
	begin
		{rst, cfgWrEn, cfgRdEn, intEvent, intxClear, slow} = 6'h20;
		{cfgByteEn, intVector, cfgOffset, cfgWrData} = '0;
		{fails, n_tests, cyc} = '0;
		repeat (20) @(posedge clk);
		#5 rst = 1'b0;
		cfgRead(8'h00, 32'h0080_0005);
		cfgRead(8'h04, 32'h0);
		$display("reset test done");
		cfgWrite(8'h00, 32'hff5f_ffff);
		cfgRead(8'h00, 32'h00d1_0005);
		cfgWrite(8'h04, 32'h1234_567b);
		cfgRead(8'h04, 32'h1234_5678);
		cfgWrite(8'h0c, 32'hffff_abc0);
		cfgRead(8'h0c, 32'h0000_abc0);
		cfgWrite(8'h08, 32'h0);
		cfgRead(8'h08, 32'h0);
		msgCase(5'h13, 64'h1234_5678, 32'h0000_abd3);
		slow = 1'b1;
		cfgWrite(8'h08, 32'h1);
		msgCase(5'h01, 64'h1_1234_5678, 32'h0000_abc1);
		cfgWrite(8'h00, 32'h0001_0000);
		msgCase(5'h1f, 64'h1_1234_5678, 32'h0000_abc0);
		$display("message test done");
		cfgWrite(8'h00, 32'h0);
		fire(5'h0);
		repeat (2) @(posedge clk);
		#5 check("legacy", intxAssert, 1'b1);
		@(posedge clk) #5 intxClear = 1'b1;
		@(posedge clk) #5 intxClear = 1'b0;
		check("cleared", intxAssert, 1'b0);
		fire(5'h0);
		repeat (2) @(posedge clk);
		base = nWrites;
		cfgWrite(8'h00, 32'h0001_0000);
		waitWr(base + 1);
		check("handover", intxAssert, 1'b0);
		$display("legacy test done");
		cfgWrite(8'h0c, 32'h0000_1200, 4'h2);
		cfgRead(8'h0c, 32'h0000_12c0);
		$display("byte lane test done");
		@(posedge clk) #5 rst = 1'b1;
		@(posedge clk) #5 rst = 1'b0;
		cfgRead(8'h00, 32'h0080_0005);
		cfgRead(8'h0c, 32'h0);
		$display("reset again test done");
		wrap_up();
	end
endmodule
